// File: src/ducrc_ctrl.v
// update, clear and reset control of a multichannel dac
`timescale 1ns/100ps
`include "ducrc_map.vh"
module ducrc_ctrl #(
  parameter [15:0] RESET_CYCLES = `DUCRC_RESET_TIME_US * `DUCRC_CLK_MHZ,
  parameter [15:0] CLEAR_CYCLES = `DUCRC_CLEAR_TIME_US * `DUCRC_CLK_MHZ
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // serial pins
  input  wire        mode_select_in,
  input  wire        sclk_in,
  input  wire        sdin_in,
  input  wire        frame_sync_n_in,
  input  wire        chain_enable_in,
  output wire        serial_out_out,
  output wire        serial_out_oe_n_out,
  // control pins
  input  wire        load_outputs_n_in,
  input  wire        clear_trigger_n_in,
  input  wire        reset_trigger_n_in,
  output wire        busy_n_out,
  // status and readback
  input  wire [5:0]  dac_sel_in,
  output wire [13:0] dac_code_out,
  output wire        dac_load_out,
  output wire        spi_mode_out,
  output wire        chain_mode_out,
  output wire [6:0]  bus_addr_out
);

  localparam NCH = `DUCRC_NUM_CHAN;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [5:0] pin_hi_s;
  wire [1:0] pin_lo_s;

  // serial clock idles high: starting it low would fake an edge
  ducrc_sync #(.W(6), .INIT(1'b1)) u_sync_hi (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({frame_sync_n_in, load_outputs_n_in, clear_trigger_n_in,
                reset_trigger_n_in, mode_select_in, sclk_in}),
    .sync_out (pin_hi_s)
  );

  ducrc_sync #(.W(2), .INIT(1'b0)) u_sync_lo (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({sdin_in, chain_enable_in}),
    .sync_out (pin_lo_s)
  );

  wire sync_n_s = pin_hi_s[5];
  wire load_n_s = pin_hi_s[4];
  wire clr_n_s  = pin_hi_s[3];
  wire rst_n_s  = pin_hi_s[2];
  wire mode_s   = pin_hi_s[1];
  wire sclk_s   = pin_hi_s[0];
  wire din_s    = pin_lo_s[1];
  wire chain_s  = pin_lo_s[0];

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  reg [4:0] prev_reg;

  always @(posedge clk_in) begin
    if (rst_in)
      prev_reg <= 5'h1F;
    else
      prev_reg <= {sync_n_s, load_n_s, clr_n_s, rst_n_s, sclk_s};
  end

  wire sync_fall = prev_reg[4] & ~sync_n_s;
  wire sync_rise = ~prev_reg[4] & sync_n_s;
  wire load_fall = prev_reg[3] & ~load_n_s;
  wire clr_fall  = prev_reg[2] & ~clr_n_s;
  wire rst_fall  = prev_reg[1] & ~rst_n_s;
  wire sclk_fall = prev_reg[0] & ~sclk_s;
  wire sclk_rise = ~prev_reg[0] & sclk_s;

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  reg [13:0] input_code_reg     [0:NCH-1];
  reg [13:0] offset_reg         [0:NCH-1];
  reg [13:0] gain_reg           [0:NCH-1];
  reg [13:0] corrected_code_reg [0:NCH-1];
  reg [13:0] dac_reg            [0:NCH-1];
  reg [13:0] clear_code_reg;
  reg [NCH-1:0] dirty_reg;
  reg [15:0] seq_cnt_reg;
  reg [15:0] clr_cnt_reg;
  reg        calc_active_reg;
  reg [5:0]  calc_ch_reg;
  reg [3:0]  calc_cnt_reg;
  reg        load_pend_reg;
  reg [23:0] shift_reg;
  reg [4:0]  bit_cnt_reg;
  reg        in_frame_reg;
  reg        sdo_reg;
  reg        sdo_oe_n_reg;
  reg        busy_n_reg;
  reg [13:0] dac_code_reg;
  reg        dac_load_reg;
  reg        spi_mode_reg;
  reg        chain_mode_reg;
  reg [6:0]  bus_addr_reg;

  // ----------------------------------------------------------------
  // derived conditions
  // ----------------------------------------------------------------
  wire in_reset = (seq_cnt_reg != 16'h0000);
  wire in_clear = (clr_cnt_reg != 16'h0000);
  // rst_in itself behaves as power-on: the sequence then runs from it
  wire busy_now = in_reset | in_clear | calc_active_reg |
                  (dirty_reg != {NCH{1'b0}});

  wire spi_mode   = mode_s;
  wire chain_mode = mode_s & chain_s;

  // lowest channel waiting for a corrected code
  reg [5:0] next_ch;
  reg       next_found;
  integer   k;

  always @* begin
    next_ch    = 6'h00;
    next_found = 1'b0;
    for (k = NCH - 1; k >= 0; k = k - 1) begin
      if (dirty_reg[k]) begin
        next_ch    = k[5:0];
        next_found = 1'b1;
      end
    end
  end

  wire [13:0] calc_result;

  ducrc_calc u_calc (
    .input_code_in (input_code_reg[calc_ch_reg]),
    .gain_in       (gain_reg[calc_ch_reg]),
    .offset_in     (offset_reg[calc_ch_reg]),
    .corrected_out (calc_result)
  );

  // ----------------------------------------------------------------
  // serial frame
  // ----------------------------------------------------------------
  wire [1:0]  cmd_sel  = shift_reg[`DUCRC_SEL_HI:`DUCRC_SEL_LO];
  wire [5:0]  cmd_ch   = shift_reg[`DUCRC_CHAN_HI:`DUCRC_CHAN_LO];
  wire [13:0] cmd_data = shift_reg[`DUCRC_DATA_HI:`DUCRC_DATA_LO];
  // a chained frame keeps the last full word that passed through
  wire len_ok = chain_mode ? (bit_cnt_reg >= `DUCRC_FRAME_BITS) :
                             (bit_cnt_reg == `DUCRC_FRAME_BITS);
  wire commit = sync_rise & in_frame_reg & spi_mode & len_ok &
                ~in_reset;
  wire ch_ok  = (cmd_ch < NCH);

  always @(posedge clk_in) begin
    if (rst_in) begin
      shift_reg    <= 24'h000000;
      bit_cnt_reg  <= 5'h00;
      in_frame_reg <= 1'b0;
      sdo_reg      <= 1'b0;
    end else if (in_reset) begin
      in_frame_reg <= 1'b0;
      bit_cnt_reg  <= 5'h00;
    end else begin
      if (sync_fall) begin
        in_frame_reg <= 1'b1;
        bit_cnt_reg  <= 5'h00;
      end else if (sync_rise) begin
        in_frame_reg <= 1'b0;
      end
      if (~sync_n_s & spi_mode & sclk_fall) begin
        shift_reg <= {shift_reg[22:0], din_s};
        if (bit_cnt_reg != 5'h1F)
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
      if (sclk_rise)
        sdo_reg <= shift_reg[23];
    end
  end

  // ----------------------------------------------------------------
  // registers, calculation, load, clear and reset sequence
  // ----------------------------------------------------------------
  // dirty bits: a write in the start cycle keeps its bit set
  reg [NCH-1:0] dirty_next;

  always @* begin
    dirty_next = dirty_reg;
    if (!calc_active_reg && next_found)
      dirty_next[next_ch] = 1'b0;
    if (commit && ch_ok && (cmd_sel != `DUCRC_SEL_CLEAR))
      dirty_next[cmd_ch] = 1'b1;
  end

  integer i;

  always @(posedge clk_in) begin
    dac_load_reg <= 1'b0;
    if (rst_in || (rst_fall && !in_reset)) begin
      for (i = 0; i < NCH; i = i + 1) begin
        input_code_reg[i]     <= `DUCRC_RST_INPUT;
        offset_reg[i]         <= `DUCRC_RST_OFFSET;
        gain_reg[i]           <= `DUCRC_RST_GAIN;
        corrected_code_reg[i] <= `DUCRC_RST_CORR;
      end
      if (rst_in) begin
        for (i = 0; i < NCH; i = i + 1)
          dac_reg[i] <= `DUCRC_RST_CORR;
        clear_code_reg <= `DUCRC_RST_CLEAR;
      end
      dirty_reg       <= {NCH{1'b0}};
      seq_cnt_reg     <= RESET_CYCLES;
      clr_cnt_reg     <= 16'h0000;
      calc_active_reg <= 1'b0;
      calc_ch_reg     <= 6'h00;
      calc_cnt_reg    <= 4'h0;
      load_pend_reg   <= 1'b0;
    end else if (in_reset) begin
      // loads and clears arriving now are dropped outright
      seq_cnt_reg <= seq_cnt_reg - 16'h0001;
    end else begin
      // clear: every dac register takes the clear code
      if (clr_fall) begin
        for (i = 0; i < NCH; i = i + 1)
          dac_reg[i] <= clear_code_reg;
        clr_cnt_reg  <= CLEAR_CYCLES;
        dac_load_reg <= 1'b1;
      end else if (in_clear) begin
        clr_cnt_reg <= clr_cnt_reg - 16'h0001;
      end

      // calculation engine, one channel at a time
      if (calc_active_reg) begin
        if (calc_cnt_reg == 4'h0) begin
          corrected_code_reg[calc_ch_reg] <= calc_result;
          calc_active_reg <= 1'b0;
        end else begin
          calc_cnt_reg <= calc_cnt_reg - 4'h1;
        end
      end else if (next_found) begin
        calc_active_reg <= 1'b1;
        calc_ch_reg     <= next_ch;
        calc_cnt_reg    <= `DUCRC_CALC_CYCLES - 4'h1;
      end

      dirty_reg <= dirty_next;

      // register writes go ahead while busy, except during the reset sequence, when commit is blocked
      if (commit) begin
        case (cmd_sel)
          `DUCRC_SEL_INPUT: begin
            if (ch_ok)
              input_code_reg[cmd_ch] <= cmd_data;
          end
          `DUCRC_SEL_OFFSET: begin
            if (ch_ok)
              offset_reg[cmd_ch] <= cmd_data;
          end
          `DUCRC_SEL_GAIN: begin
            if (ch_ok)
              gain_reg[cmd_ch] <= cmd_data;
          end
          default: begin
            clear_code_reg <= cmd_data;
          end
        endcase
      end

      // load: immediate when idle, else one merged deferred update
      if (!clr_fall) begin
        if (!busy_now && (load_fall || load_pend_reg)) begin
          for (i = 0; i < NCH; i = i + 1)
            dac_reg[i] <= corrected_code_reg[i];
          dac_load_reg  <= 1'b1;
          load_pend_reg <= 1'b0;
        end else if (busy_now && load_fall) begin
          load_pend_reg <= 1'b1;
        end
      end else if (load_fall) begin
        load_pend_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin outputs and status
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      busy_n_reg     <= 1'b0;
      sdo_oe_n_reg   <= 1'b1;
      dac_code_reg   <= 14'h0000;
      spi_mode_reg   <= 1'b0;
      chain_mode_reg <= 1'b0;
      bus_addr_reg   <= 7'h00;
    end else begin
      busy_n_reg     <= ~busy_now;
      // pin floats outside chain mode so chained parts can share it
      sdo_oe_n_reg   <= ~(chain_mode & ~in_reset);
      dac_code_reg   <= (dac_sel_in < NCH) ? dac_reg[dac_sel_in]
                                           : 14'h0000;
      spi_mode_reg   <= spi_mode;
      chain_mode_reg <= chain_mode;
      // address pins share the frame-sync and chain-enable pins
      bus_addr_reg   <= {`DUCRC_ADDR_BASE, chain_s, sync_n_s};
    end
  end

  assign serial_out_out      = sdo_reg;
  assign serial_out_oe_n_out = sdo_oe_n_reg;
  assign busy_n_out          = busy_n_reg;
  assign dac_code_out        = dac_code_reg;
  assign dac_load_out        = dac_load_reg;
  assign spi_mode_out        = spi_mode_reg;
  assign chain_mode_out      = chain_mode_reg;
  assign bus_addr_out        = bus_addr_reg;

endmodule

// File: include/ducrc_map.vh
// constants for the update, clear and reset control block
`ifndef DUCRC_MAP_VH
`define DUCRC_MAP_VH

// ----------------------------------------------------------------
// clock and sequence timing
// ----------------------------------------------------------------
`define DUCRC_CLK_MHZ        200
`define DUCRC_RESET_TIME_US  270
`define DUCRC_CLEAR_TIME_US  35
`define DUCRC_CALC_CYCLES    4'h4

// ----------------------------------------------------------------
// channel and code sizes
// ----------------------------------------------------------------
`define DUCRC_NUM_CHAN       40
`define DUCRC_CODE_W         14
`define DUCRC_FRAME_BITS     5'h18

// ----------------------------------------------------------------
// serial frame field positions
// ----------------------------------------------------------------
`define DUCRC_SEL_HI         23
`define DUCRC_SEL_LO         22
`define DUCRC_CHAN_HI        21
`define DUCRC_CHAN_LO        16
`define DUCRC_DATA_HI        13
`define DUCRC_DATA_LO        0

// ----------------------------------------------------------------
// frame register selects
// ----------------------------------------------------------------
`define DUCRC_SEL_INPUT      2'h0
`define DUCRC_SEL_OFFSET     2'h1
`define DUCRC_SEL_GAIN       2'h2
`define DUCRC_SEL_CLEAR      2'h3

// ----------------------------------------------------------------
// power-on values, midscale and full-scale codes
// ----------------------------------------------------------------
`define DUCRC_RST_INPUT      14'h0000
`define DUCRC_RST_OFFSET     14'h2000
`define DUCRC_RST_GAIN       14'h3FFF
`define DUCRC_RST_CORR       14'h0000
`define DUCRC_RST_CLEAR      14'h0000
`define DUCRC_MID_CODE       17'h02000
`define DUCRC_MAX_CODE       17'h03FFF

// ----------------------------------------------------------------
// bus slave address upper bits (arbitrary value)
// ----------------------------------------------------------------
`define DUCRC_ADDR_BASE      5'h15

`endif

// File: src/ducrc_sync.v
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module ducrc_sync #(
  parameter W    = 1,
  parameter INIT = 1'b0
) (
  // clock and reset
  input  wire         clk_in,
  input  wire         rst_in,
  // pins and synchronised levels
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] stable_reg;

  always @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg   <= {W{INIT}};
      stable_reg <= {W{INIT}};
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule

// File: src/ducrc_calc.v
// corrected channel code from input, gain and offset
`timescale 1ns/100ps
`include "ducrc_map.vh"
module ducrc_calc (
  // operands
  input  wire [13:0] input_code_in,
  input  wire [13:0] gain_in,
  input  wire [13:0] offset_in,
  // result
  output wire [13:0] corrected_out
);

  wire [28:0] prod;
  wire [16:0] sum;

  // code * (gain + 1) / 2^14 + offset - midscale
  assign prod = input_code_in * ({1'b0, gain_in} + 15'h0001);
  assign sum  = {2'h0, prod[28:14]} + {3'h0, offset_in} - `DUCRC_MID_CODE;

  // negative results clamp to zero, overflow clamps to full scale
  assign corrected_out = sum[16] ? 14'h0000 :
                         (sum > `DUCRC_MAX_CODE) ? 14'h3FFF : sum[13:0];

endmodule

// File: tb/ducrc_ctrl_sva.sv
// port assertions for the update, clear and reset control
`timescale 1ns/100ps
module ducrc_ctrl_sva #(
  parameter [15:0] RESET_CYCLES = 16'h0032,
  parameter [15:0] CLEAR_CYCLES = 16'h0014
) (
  // clock and reset
  input wire        clk_in,
  input wire        rst_in,
  // serial pins
  input wire        mode_select_in,
  input wire        sclk_in,
  input wire        sdin_in,
  input wire        frame_sync_n_in,
  input wire        chain_enable_in,
  input wire        serial_out_out,
  input wire        serial_out_oe_n_out,
  // control pins
  input wire        load_outputs_n_in,
  input wire        clear_trigger_n_in,
  input wire        reset_trigger_n_in,
  input wire        busy_n_out,
  // status and readback
  input wire [5:0]  dac_sel_in,
  input wire [13:0] dac_code_out,
  input wire        dac_load_out,
  input wire        spi_mode_out,
  input wire        chain_mode_out,
  input wire [6:0]  bus_addr_out
);
  // ----------------------------------------
  // length and cause of each busy period
  // ----------------------------------------
  logic [15:0] low_cnt_reg;
  logic [1:0]  cause_reg;
  default clocking cb @(posedge clk_in); endclocking
  // cause 2 is a reset sequence, 1 a clear, 0 anything else
  always @(posedge clk_in) begin
    if (rst_in) begin
      low_cnt_reg <= 16'h0000;
      cause_reg   <= 2'h2;
    end else begin
      low_cnt_reg <= busy_n_out ? 16'h0000 : low_cnt_reg + 16'h0001;
      if (busy_n_out && $fell(reset_trigger_n_in))
        cause_reg <= 2'h2;
      else if ($fell(busy_n_out) && $past(dac_load_out))
        cause_reg <= 2'h1;
      else if ($rose(busy_n_out))
        cause_reg <= 2'h0;
    end
  end
  chk_busy_in_rst: assert property (rst_in |=> !busy_n_out && serial_out_oe_n_out)
    else $error("busy or serial out active in reset");
  chk_load_pulse: assert property (disable iff (rst_in) dac_load_out |=> !dac_load_out)
    else $error("load pulse longer than one cycle");
  chk_load_gate: assert property (disable iff (rst_in) dac_load_out |-> busy_n_out || $fell(busy_n_out))
    else $error("dac update inside a busy period");
  chk_rst_no_load: assert property (disable iff (rst_in) cause_reg == 2'h2 && !busy_n_out |-> !dac_load_out)
    else $error("dac update during reset sequence");
  chk_clear_busy_len: assert property (disable iff (rst_in) $rose(busy_n_out) && cause_reg == 2'h1 |-> low_cnt_reg >= CLEAR_CYCLES - 16'h0001 && low_cnt_reg <= CLEAR_CYCLES + 16'h0001)
    else $error("clear busy length wrong");
  chk_reset_busy_len: assert property (disable iff (rst_in) $rose(busy_n_out) && cause_reg == 2'h2 |-> low_cnt_reg >= RESET_CYCLES - 16'h0002 && low_cnt_reg <= RESET_CYCLES + 16'h0003)
    else $error("reset busy length wrong");
  chk_spi_mode_sel: assert property (disable iff (rst_in) $stable(mode_select_in)[*5] |-> spi_mode_out == mode_select_in)
    else $error("mode output does not follow pin");
  chk_chain_mode_on: assert property (disable iff (rst_in) $stable({mode_select_in, chain_enable_in})[*5] |-> chain_mode_out == (mode_select_in && chain_enable_in))
    else $error("chain mode wrong");
  chk_addr_pins: assert property (disable iff (rst_in) $stable({chain_enable_in, frame_sync_n_in})[*5] |-> bus_addr_out[1:0] == {chain_enable_in, frame_sync_n_in})
    else $error("bus address low bits wrong");
  chk_sdo_rise: assert property (disable iff (rst_in) $changed(serial_out_out) |-> sclk_in)
    else $error("serial out moved while clock low");
  chk_oe_chain: assert property (disable iff (rst_in) !serial_out_oe_n_out |-> chain_mode_out || $past(chain_mode_out))
    else $error("serial out driven outside chain mode");
endmodule

// File: tb/ducrc_host_model.sv
// host serial port: frames msb first, clock idles high
`timescale 1ns/100ps
module ducrc_host_model (
  // pins towards the device
  output logic        sclk_out,
  output logic        sdin_out,
  output logic        frame_sync_n_out,
  // device serial out and what it carried last frame
  input  wire         serial_out_in,
  output logic [23:0] echo_out
);
  initial begin
    sclk_out = 1'b1;
    sdin_out = 1'b0;
    frame_sync_n_out = 1'b1;
    echo_out = 24'h000000;
  end
  // odd offsets keep this clock unrelated to the system clock
  task automatic send(input logic [23:0] word);
    #1.1 frame_sync_n_out = 1'b0;
    #62.5;
    for (int i = 23; i >= 0; i--) begin
      sdin_out = word[i];
      #31.2 sclk_out = 1'b0;
      echo_out = {echo_out[22:0], serial_out_in};
      #62.5 sclk_out = 1'b1;
      #31.3;
    end
    #31.2 frame_sync_n_out = 1'b1;
    sdin_out = ~sdin_out;
  endtask
  task automatic set_pin(input logic v);
    frame_sync_n_out = v;
  endtask
endmodule

// File: tb/dac_update_clear_reset_control_tb_top.sv
// bench: host model, integer reference and the control block
`timescale 1ns/100ps
module dac_update_clear_reset_control_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mode = 1'b1;
  logic        chain = 1'b0;
  logic        ld_n = 1'b1;
  logic        clr_n = 1'b1;
  logic        rsp_n = 1'b1;
  logic [5:0]  sel = 6'h00;
  wire         sclk, sdin, fs_n, so, so_oe_n, so_w, busy_n, dld, spi, chm;
  wire  [13:0] code;
  wire  [6:0]  addr;
  wire  [23:0] echo;
  logic [23:0] last_w, pw;
  int          mismatches = 0;
  int          checked = 0;
  int          loads = 0;
  int          seed = 32'hB3608FBD;
  int          inp[40], off[40], gn[40], dacm[40];
  int          clr, ch, n;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (dld === 1'b1) loads++;
  // released serial out shows the opposite level, never a match
  assign so_w = so_oe_n ? ~so : so;
  ducrc_ctrl #(.RESET_CYCLES(16'h0032), .CLEAR_CYCLES(16'h0014)) dut (
    .clk_in(clk), .rst_in(rst), .mode_select_in(mode), .sclk_in(sclk),
    .sdin_in(sdin), .frame_sync_n_in(fs_n), .chain_enable_in(chain),
    .serial_out_out(so), .serial_out_oe_n_out(so_oe_n),
    .load_outputs_n_in(ld_n), .clear_trigger_n_in(clr_n),
    .reset_trigger_n_in(rsp_n), .busy_n_out(busy_n), .dac_sel_in(sel),
    .dac_code_out(code), .dac_load_out(dld), .spi_mode_out(spi),
    .chain_mode_out(chm), .bus_addr_out(addr));
  ducrc_host_model host (.sclk_out(sclk), .sdin_out(sdin),
    .frame_sync_n_out(fs_n), .serial_out_in(so_w), .echo_out(echo));
  // ----------------------------------------
  // checks and reference model
  // ----------------------------------------
  task conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cmp_val(input logic [23:0] got, input logic [23:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task cmp_dac(input int c);
    @(posedge clk) sel <= c[5:0];
    repeat (2) @(posedge clk);
    #1 cmp_val({10'h000, code}, 24'(dacm[c]), "dac code");
  endtask
  task wait_busy(input logic v, input int lim);
    int i;
    i = 0;
    while (busy_n !== v && i < lim) begin
      @(posedge clk);
      i++;
    end
    cmp_val({23'h0, busy_n}, {23'h0, v}, "busy level");
    if (busy_n !== v) conclude;
  endtask
  task defaults;
    for (int c = 0; c < 40; c++) begin
      inp[c] = 0;
      off[c] = 8192;
      gn[c] = 16383;
    end
  endtask
  task apply;
    int v;
    for (int c = 0; c < 40; c++) begin
      v = ((inp[c] * (gn[c] + 1)) >>> 14) + off[c] - 8192;
      dacm[c] = v < 0 ? 0 : v > 16383 ? 16383 : v;
    end
  endtask
  task wr(input int s, input int c, input int d);
    last_w = {s[1:0], c[5:0], 2'h0, d[13:0]};
    host.send(last_w);
    case (s)
      0: inp[c] = d;
      1: off[c] = d;
      2: gn[c] = d;
      default: clr = d;
    endcase
    if (s < 3) wait_busy(1'b0, 20);
    wait_busy(1'b1, 400);
  endtask
  task pulse(input int w);
    @(posedge clk);
    if (w == 0) ld_n <= 1'b0;
    else clr_n <= 1'b0;
    repeat (4) @(posedge clk);
    ld_n <= 1'b1;
    clr_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    defaults;
    clr = 0;
    for (int c = 0; c < 40; c++) dacm[c] = 0;
    repeat (20) @(posedge clk);
    cmp_val({23'h0, busy_n}, 24'h0, "busy in reset");
    rst <= 1'b0;
    wait_busy(1'b1, 200);
    for (int k = 0; k < 6; k++) begin
      ch = k == 0 ? 0 : k == 1 ? 39 : {$random(seed)} % 40;
      for (int s = 0; s < 3; s++) wr(s, ch, $random(seed) & 16'h3FFF);
      n = loads;
      pulse(0);
      apply;
      cmp_val(24'(loads - n), 24'h1, "load pulses");
      cmp_dac(ch);
    end
    wr(3, 0, $random(seed) & 16'h3FFF);
    n = loads;
    pulse(1);
    for (int c = 0; c < 40; c++) dacm[c] = clr;
    wait_busy(1'b1, 100);
    cmp_dac(0);
    cmp_dac(39);
    // two loads inside a clear must give one late update
    @(posedge clk) clr_n <= 1'b0;
    repeat (5) @(posedge clk);
    clr_n <= 1'b1;
    ld_n <= 1'b0;
    repeat (4) @(posedge clk);
    ld_n <= 1'b1;
    repeat (4) @(posedge clk);
    ld_n <= 1'b0;
    repeat (4) @(posedge clk);
    ld_n <= 1'b1;
    wait_busy(1'b1, 100);
    repeat (3) @(posedge clk);
    apply;
    cmp_val(24'(loads - n), 24'h3, "merged loads");
    cmp_dac(39);
    // a frame ending inside a clear busy period still lands
    fork
      host.send({2'h0, 6'h05, 2'h0, 14'h1234});
      begin
        repeat (605) @(posedge clk);
        clr_n <= 1'b0;
        repeat (4) @(posedge clk);
        clr_n <= 1'b1;
      end
    join
    inp[5] = 32'h1234;
    wait_busy(1'b1, 400);
    pulse(0);
    apply;
    cmp_dac(5);
    // a load arriving in the calculation window waits for it
    host.send({2'h0, 6'h09, 2'h0, 14'h2ABC});
    inp[9] = 32'h2ABC;
    n = loads;
    pulse(0);
    wait_busy(1'b1, 400);
    repeat (3) @(posedge clk);
    apply;
    cmp_val(24'(loads - n), 24'h1, "deferred load");
    cmp_dac(9);
    wr(0, 7, 16383);
    n = loads;
    @(posedge clk) rsp_n <= 1'b0;
    wait_busy(1'b0, 20);
    pulse(0);
    wait_busy(1'b1, 200);
    cmp_val(24'(loads - n), 24'h0, "load in reset");
    cmp_dac(7);
    defaults;
    repeat (100) @(posedge clk);
    cmp_val({23'h0, busy_n}, 24'h1, "level restart");
    wr(2, 7, 16'h1000);
    pulse(0);
    apply;
    cmp_dac(7);
    rsp_n <= 1'b1;
    @(posedge clk) chain <= 1'b1;
    repeat (6) @(posedge clk);
    cmp_val({23'h0, so_oe_n}, 24'h0, "chain drive");
    wr(0, 3, $random(seed) & 16'h3FFF);
    pw = last_w;
    wr(0, 4, $random(seed) & 16'h3FFF);
    cmp_val(echo, pw, "chain echo");
    chain <= 1'b0;
    repeat (6) @(posedge clk);
    cmp_val({23'h0, so_oe_n}, 24'h1, "released");
    mode <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      @(posedge clk) chain <= a[1];
      #1 host.set_pin(a[0]);
      repeat (6) @(posedge clk);
      cmp_val({22'h0, addr[1:0]}, 24'(a), "bus address");
      cmp_val({23'h0, spi}, 24'h0, "mode");
    end
    conclude;
  end
endmodule
bind ducrc_ctrl ducrc_ctrl_sva #(.RESET_CYCLES(RESET_CYCLES),
  .CLEAR_CYCLES(CLEAR_CYCLES)) chk (.clk_in(clk_in), .rst_in(rst_in),
  .mode_select_in(mode_select_in), .sclk_in(sclk_in), .sdin_in(sdin_in),
  .frame_sync_n_in(frame_sync_n_in), .chain_enable_in(chain_enable_in),
  .serial_out_out(serial_out_out),
  .serial_out_oe_n_out(serial_out_oe_n_out),
  .load_outputs_n_in(load_outputs_n_in),
  .clear_trigger_n_in(clear_trigger_n_in),
  .reset_trigger_n_in(reset_trigger_n_in), .busy_n_out(busy_n_out),
  .dac_sel_in(dac_sel_in), .dac_code_out(dac_code_out),
  .dac_load_out(dac_load_out), .spi_mode_out(spi_mode_out),
  .chain_mode_out(chain_mode_out), .bus_addr_out(bus_addr_out));
